//--- dv/alarm_regs_chk_sva.sv
// checker for bus handshakes and aux channel 0 alarm flag
`timescale 1ns/1ps
`default_nettype none
module alarm_regs_chk
    import alarm_window_pkg::*;
#(
    parameter int DW = 12
) (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [3:0]            aux_sample_valid,
    input wire logic [4*DW-1:0]       aux_sample,
    input wire logic [1:0]            aux_pair_signed,
    input wire logic [3:0]            aux_upper_bound,
    input wire logic [4*DW-1:0]       aux_upper_bound_field,
    input wire logic [4*DW-1:0]       aux_lower_bound_field,
    input wire logic [NUM_ALARMS-1:0] input_alarm_flag,
    input wire logic                  irq
);
    // channel 0 sample taken as straight binary
    logic tk0;
    assign tk0 = aux_sample_valid[0] & aux_upper_bound[0] & ~aux_pair_signed[0];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_IRQ_RESET: assert property (disable iff (1'b0) !aresetn |=> !irq && input_alarm_flag == '0)
        else $error("irq or flag set after reset");
    AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    AST_AUX_HIGH: assert property (tk0 && aux_sample[DW-1:0] > aux_upper_bound_field[DW-1:0]
        |-> ##[1:2] input_alarm_flag[0])
        else $error("alarm above upper bound missing");
    AST_AUX_LOW: assert property (tk0 && aux_sample[DW-1:0] < aux_lower_bound_field[DW-1:0]
        |-> ##[1:2] input_alarm_flag[0])
        else $error("alarm below lower bound missing");
    AST_AUX_HOLD: assert property ($fell(input_alarm_flag[0])
        |-> $past(aux_sample_valid[0]) || $past(aux_sample_valid[0], 2))
        else $error("alarm released without a sample");
endmodule // alarm_regs_chk
bind alarm_threshold_hysteresis_regs alarm_regs_chk #(.DW(DW)) u_chk (.*);
`default_nettype wire

//--- dv/axil_host.sv
// host model driving the register bus as an axi4-lite master
`timescale 1ns/1ps
`default_nettype none
module axil_host (
    input  wire logic        aclk,
    output var  logic [11:0] s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    output var  logic [11:0] s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready
);
    // idle bus; responses always accepted
    initial begin
        s_axi_awaddr = 12'h000;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 12'h000;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
    end
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
        logic ah;
        logic wh;
        ah = 1'b0;
        wh = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ah && wh)) begin
            @(posedge aclk);
            if (!ah && s_axi_awready) begin
                ah = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!wh && s_axi_wready) begin
                wh = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~{16'h0000, d};
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    // read: address held until taken, then wait for data
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule // axil_host
`default_nettype wire

//--- dv/tb_alarm_threshold_hysteresis_regs.sv
// testbench for the alarm window and release margin register bank
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_threshold_hysteresis_regs
    import alarm_window_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, aux_sample_valid = 4'h0, aux_upper_bound = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, aux_pair_signed = 2'h0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [47:0] aux_sample = 48'h0, aux_upper_bound_field = {4{12'h0C8}};
    logic [47:0] aux_lower_bound_field = {4{12'h064}};
    logic [2:0] temp_sample_valid = 3'h0;
    logic [35:0] temp_sample = 36'h0;
    logic [6:0] input_alarm_flag;
    int miscompares = 0, n_compared = 0, cyc = 0;
    logic [7:0] idx_t [9] = '{IDX_ON_DIE_UPPER, IDX_ON_DIE_LOWER, IDX_REM1_UPPER,
        IDX_REM1_LOWER, IDX_REM2_UPPER, IDX_REM2_LOWER, IDX_AUX_MARGIN_A,
        IDX_AUX_MARGIN_B, IDX_TEMP_MARGIN};
    logic [15:0] rst_t [9] = '{16'h07FF, 16'h0800, 16'h07FF, 16'h0800, 16'h07FF,
        16'h0800, 16'h0810, 16'h0810, 16'h2108};
    logic [15:0] ones_t [9] = '{16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF,
        16'h0FFF, 16'h7FFE, 16'h7FFE, 16'h7FFF};
    alarm_threshold_hysteresis_regs dut (.*);
    axil_host u_host (.*);
    always #5 aclk = ~aclk;
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [15:0] exp);
        u_host.rd({2'b00, idx, 2'b00}, d, r);
        chk(d, {16'h0000, exp});
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    task automatic wrc(input logic [7:0] idx, input logic [15:0] v);
        u_host.wr({2'b00, idx, 2'b00}, v, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    // one sample pulse on channel ch, then let the flag settle
    task automatic samp(input int ch, input logic [11:0] v, input logic f);
        if (ch < 4) begin
            aux_sample[ch*12 +: 12] <= v;
            aux_sample_valid[ch] <= 1'b1;
        end else begin
            temp_sample[(ch-4)*12 +: 12] <= v;
            temp_sample_valid[ch-4] <= 1'b1;
        end
        @(posedge aclk);
        aux_sample_valid <= 4'h0;
        temp_sample_valid <= 3'h0;
        repeat (3) @(posedge aclk);
        chk({31'h0, input_alarm_flag[ch]}, {31'h0, f});
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 9; i++) rdc(idx_t[i], rst_t[i]);
        for (int i = 0; i < 9; i++) begin
            wrc(idx_t[i], 16'hFFFF);
            rdc(idx_t[i], ones_t[i]);
        end
        u_host.rd(12'h040, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        u_host.wr(12'h040, 16'h1234, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wrc(IDX_AUX_MARGIN_A, 16'h0A08);
        wrc(IDX_TEMP_MARGIN, 16'h2102);
        for (int i = 0; i < 6; i++) wrc(idx_t[i], rst_t[i]);
        wrc(IDX_ALARM_MASK, 16'h0001);
        samp(0, 12'h0FA, 1'b1);
        chk({31'h0, irq}, 32'h1);
        samp(0, 12'h0C3, 1'b1);
        samp(0, 12'h096, 1'b0);
        rdc(IDX_ALARM_STATUS, 16'h0001);
        rdc(IDX_ALARM_STATUS, 16'h0000);
        chk({31'h0, irq}, 32'h0);
        samp(1, 12'h0FA, 1'b1);
        samp(1, 12'h0C3, 1'b0);
        samp(0, 12'h032, 1'b1);
        wrc(IDX_ALARM_MASK, 16'h0000);
        rdc(IDX_ALARM_MASK, 16'h0000);
        chk({31'h0, irq}, 32'h0);
        wrc(IDX_ON_DIE_UPPER, 16'h0100);
        samp(4, 12'h120, 1'b1);
        samp(4, 12'h0F8, 1'b1);
        samp(4, 12'h0E0, 1'b0);
        wrc(IDX_REM2_UPPER, 16'h0100);
        samp(6, 12'h120, 1'b1);
        samp(6, 12'h0D0, 1'b1);
        wrc(IDX_REM1_LOWER, 16'h0100);
        wrc(IDX_REM1_UPPER, 16'h0080);
        samp(5, 12'h0C0, 1'b1);
        aux_upper_bound <= 4'h7;
        samp(3, 12'h0FA, 1'b0);
        ce <= 1'b0;
        samp(2, 12'h0FA, 1'b0);
        ce <= 1'b1;
        rdc(IDX_ALARM_LEVEL, 16'h0061);
        rdc(IDX_ALARM_STATUS, 16'h0073);
        tally_and_finish();
    end
endmodule // tb_alarm_threshold_hysteresis_regs
`default_nettype wire

//--- hw/alarm_threshold_hysteresis_regs.sv
// alarm window bounds, release margins and alarm flags for aux and temperature inputs
`timescale 1ns/1ps
`default_nettype none
module alarm_threshold_hysteresis_regs
    import alarm_window_pkg::*;
#(
    parameter int AW = 12,
    parameter int DW = 12
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic [3:0]    aux_sample_valid,
    input  wire logic [4*DW-1:0] aux_sample,
    input  wire logic [1:0]    aux_pair_signed,
    input  wire logic [2:0]    temp_sample_valid,
    input  wire logic [3*DW-1:0] temp_sample,
    input  wire logic [3:0]    aux_upper_bound,
    input  wire logic [4*DW-1:0] aux_upper_bound_field,
    input  wire logic [4*DW-1:0] aux_lower_bound_field,
    output logic [NUM_ALARMS-1:0] input_alarm_flag,
    output logic               irq
);
    // bound registers: index 0 on-die, 1 remote one, 2 remote two
    logic [DW-1:0] upper_q [3];
    logic [DW-1:0] upper_d [3];
    logic [DW-1:0] lower_q [3];
    logic [DW-1:0] lower_d [3];
    logic [15:0]   aux_margin_a_q, aux_margin_a_d;
    logic [15:0]   aux_margin_b_q, aux_margin_b_d;
    logic [15:0]   temp_margin_q, temp_margin_d;
    logic [NUM_ALARMS-1:0] status_q, status_d;
    logic [NUM_ALARMS-1:0] mask_q, mask_d;
    logic [NUM_ALARMS-1:0] flag_prev_q;
    logic [NUM_ALARMS-1:0] rise;
    logic          wr_en;
    logic [7:0]    wr_index;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;
    logic          wr_hit;
    logic          rd_en;
    logic [7:0]    rd_index;
    logic [31:0]   rd_data;
    logic          rd_hit;
    logic [15:0]   wmask;
    logic [DW-1:0] margin [NUM_ALARMS];
    logic [DW-1:0] hi_f [NUM_ALARMS];
    logic [DW-1:0] lo_f [NUM_ALARMS];
    logic [DW-1:0] smp [NUM_ALARMS];
    logic [NUM_ALARMS-1:0] svalid;
    logic [NUM_ALARMS-1:0] ssigned;

    axil_reg_slave #(.AW(AW)) u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_index      (wr_index),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_hit        (wr_hit),
        .rd_en         (rd_en),
        .rd_index      (rd_index),
        .rd_data       (rd_data),
        .rd_hit        (rd_hit)
    );

    // byte enables expanded over the low 16 data bits
    assign wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    // address decode for writes
    always_comb begin
        unique case (wr_index)
            IDX_ON_DIE_UPPER, IDX_ON_DIE_LOWER, IDX_REM1_UPPER, IDX_REM1_LOWER,
            IDX_REM2_UPPER, IDX_REM2_LOWER, IDX_AUX_MARGIN_A, IDX_AUX_MARGIN_B,
            IDX_TEMP_MARGIN, IDX_ALARM_STATUS, IDX_ALARM_MASK, IDX_ALARM_LEVEL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // register writes, each bound and margin kept apart
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            upper_d[i] = upper_q[i];
            lower_d[i] = lower_q[i];
        end
        aux_margin_a_d = aux_margin_a_q;
        aux_margin_b_d = aux_margin_b_q;
        temp_margin_d  = temp_margin_q;
        mask_d         = mask_q;
        if (wr_en) begin
            for (int i = 0; i < 3; i++) begin
                if (wr_index == IDX_ON_DIE_UPPER + 8'(2 * i)) begin
                    upper_d[i] = (upper_q[i] & ~wmask[DW-1:0])
                               | (wr_data[DW-1:0] & wmask[DW-1:0]);
                end
                if (wr_index == IDX_ON_DIE_LOWER + 8'(2 * i)) begin
                    lower_d[i] = (lower_q[i] & ~wmask[DW-1:0])
                               | (wr_data[DW-1:0] & wmask[DW-1:0]);
                end
            end
            if (wr_index == IDX_AUX_MARGIN_A) begin
                aux_margin_a_d = (aux_margin_a_q & ~wmask) | (wr_data[15:0] & wmask);
            end
            if (wr_index == IDX_AUX_MARGIN_B) begin
                aux_margin_b_d = (aux_margin_b_q & ~wmask) | (wr_data[15:0] & wmask);
            end
            if (wr_index == IDX_TEMP_MARGIN) begin
                temp_margin_d = (temp_margin_q & ~wmask) | (wr_data[15:0] & wmask);
            end
            if (wr_index == IDX_ALARM_MASK && wr_strb[0]) begin
                mask_d = wr_data[NUM_ALARMS-1:0];
            end
        end
    end

    // read mux; reserved bits read as zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (rd_index)
            IDX_ON_DIE_UPPER: rd_data[DW-1:0] = upper_q[0];
            IDX_ON_DIE_LOWER: rd_data[DW-1:0] = lower_q[0];
            IDX_REM1_UPPER:   rd_data[DW-1:0] = upper_q[1];
            IDX_REM1_LOWER:   rd_data[DW-1:0] = lower_q[1];
            IDX_REM2_UPPER:   rd_data[DW-1:0] = upper_q[2];
            IDX_REM2_LOWER:   rd_data[DW-1:0] = lower_q[2];
            IDX_AUX_MARGIN_A: rd_data[15:0]   = aux_margin_a_q & 16'h7FFE;
            IDX_AUX_MARGIN_B: rd_data[15:0]   = aux_margin_b_q & 16'h7FFE;
            IDX_TEMP_MARGIN:  rd_data[15:0]   = temp_margin_q & 16'h7FFF;
            IDX_ALARM_STATUS: rd_data[NUM_ALARMS-1:0] = status_q;
            IDX_ALARM_MASK:   rd_data[NUM_ALARMS-1:0] = mask_q;
            IDX_ALARM_LEVEL:  rd_data[NUM_ALARMS-1:0] = input_alarm_flag;
            default:          rd_hit = 1'b0;
        endcase
    end

    // per-alarm operands: temperature margins scaled, aux margins taken as is, bounds and samples routed
    always_comb begin
        margin[0] = DW'(aux_margin_a_q[AUX_HI_LSB +: 7]);
        margin[1] = DW'(aux_margin_a_q[AUX_LO_LSB +: 7]);
        margin[2] = DW'(aux_margin_b_q[AUX_HI_LSB +: 7]);
        margin[3] = DW'(aux_margin_b_q[AUX_LO_LSB +: 7]);
        margin[4] = DW'({temp_margin_q[ON_DIE_MARGIN_LSB +: 5], 3'b000});
        margin[5] = DW'({temp_margin_q[REM1_MARGIN_LSB +: 5], 3'b000});
        margin[6] = DW'({temp_margin_q[REM2_MARGIN_LSB +: 5], 3'b000});
        for (int i = 0; i < 4; i++) begin
            hi_f[i]    = aux_upper_bound_field[i*DW +: DW];
            lo_f[i]    = aux_lower_bound_field[i*DW +: DW];
            smp[i]     = aux_sample[i*DW +: DW];
            svalid[i]  = aux_sample_valid[i] && aux_upper_bound[i];
            ssigned[i] = aux_pair_signed[i/2];
        end
        for (int i = 0; i < 3; i++) begin
            hi_f[4+i]    = upper_q[i];
            lo_f[4+i]    = lower_q[i];
            smp[4+i]     = temp_sample[i*DW +: DW];
            svalid[4+i]  = temp_sample_valid[i];
            ssigned[4+i] = 1'b1;
        end
    end

    // one comparator per monitored input
    for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alarm
        window_alarm #(.W(DW)) u_win (
            .aclk              (aclk),
            .aresetn           (aresetn),
            .ce                (ce),
            .sample_valid      (svalid[g]),
            .sample            (smp[g]),
            .upper_bound_field (hi_f[g]),
            .lower_bound_field (lo_f[g]),
            .margin            (margin[g]),
            .signed_mode       (ssigned[g]),
            .input_alarm_flag  (input_alarm_flag[g])
        );
    end

    // sticky status: a new raise wins over the clear by read
    assign rise = input_alarm_flag & ~flag_prev_q;
    always_comb begin
        status_d = status_q;
        if (rd_en && rd_index == IDX_ALARM_STATUS) begin
            status_d = '0;
        end
        status_d = status_d | rise;
    end

    // state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                upper_q[i] <= UPPER_RESET;
                lower_q[i] <= LOWER_RESET;
            end
            aux_margin_a_q <= AUX_MARGIN_RESET;
            aux_margin_b_q <= AUX_MARGIN_RESET;
            temp_margin_q  <= TEMP_MARGIN_RESET;
            status_q       <= '0;
            mask_q         <= '0;
            flag_prev_q    <= '0;
        end else if (ce) begin
            upper_q        <= upper_d;
            lower_q        <= lower_d;
            aux_margin_a_q <= aux_margin_a_d;
            aux_margin_b_q <= aux_margin_b_d;
            temp_margin_q  <= temp_margin_d;
            status_q       <= status_d;
            mask_q         <= mask_d;
            flag_prev_q    <= input_alarm_flag;
        end
    end

    assign irq = |(status_q & mask_q);
endmodule : alarm_threshold_hysteresis_regs
`default_nettype wire

//--- hw/alarm_window_pkg.sv
// constants for the alarm window and release margin register bank
package alarm_window_pkg;
    // register word indices (byte address is four times the index)
    localparam logic [7:0]  IDX_ON_DIE_UPPER  = 8'h62;
    localparam logic [7:0]  IDX_ON_DIE_LOWER  = 8'h63;
    localparam logic [7:0]  IDX_REM1_UPPER    = 8'h64;
    localparam logic [7:0]  IDX_REM1_LOWER    = 8'h65;
    localparam logic [7:0]  IDX_REM2_UPPER    = 8'h66;
    localparam logic [7:0]  IDX_REM2_LOWER    = 8'h67;
    localparam logic [7:0]  IDX_AUX_MARGIN_A  = 8'h68;
    localparam logic [7:0]  IDX_AUX_MARGIN_B  = 8'h69;
    localparam logic [7:0]  IDX_TEMP_MARGIN   = 8'h6A;
    localparam logic [7:0]  IDX_ALARM_STATUS  = 8'h70;
    localparam logic [7:0]  IDX_ALARM_MASK    = 8'h71;
    localparam logic [7:0]  IDX_ALARM_LEVEL   = 8'h72;
    // reset values
    localparam logic [11:0] UPPER_RESET       = 12'h7FF;
    localparam logic [11:0] LOWER_RESET       = 12'h800;
    localparam logic [15:0] AUX_MARGIN_RESET  = 16'h0810;
    localparam logic [15:0] TEMP_MARGIN_RESET = 16'h2108;
    // field positions
    localparam int          AUX_HI_LSB        = 8;
    localparam int          AUX_LO_LSB        = 1;
    localparam int          REM2_MARGIN_LSB   = 10;
    localparam int          REM1_MARGIN_LSB   = 5;
    localparam int          ON_DIE_MARGIN_LSB = 0;
    localparam int          TEMP_FRAC_BITS    = 3;
    // alarm count: four aux inputs then on-die, remote one, remote two
    localparam int          NUM_ALARMS        = 7;
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;
endpackage : alarm_window_pkg

//--- hw/axil_reg_slave.sv
// axi4-lite slave front end turning bus transfers into word strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave
    import alarm_window_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic               wr_en,
    output logic [7:0]         wr_index,
    output logic [31:0]        wr_data,
    output logic [3:0]         wr_strb,
    input  wire logic          wr_hit,
    output logic               rd_en,
    output logic [7:0]         rd_index,
    input  wire logic [31:0]   rd_data,
    input  wire logic          rd_hit
);
    logic          aw_full_q, aw_full_d;
    logic          w_full_q, w_full_d;
    logic [AW-1:0] awaddr_q, awaddr_d;
    logic [31:0]   wdata_q, wdata_d;
    logic [3:0]    wstrb_q, wstrb_d;
    logic          bvalid_q, bvalid_d;
    logic [1:0]    bresp_q, bresp_d;
    logic          rvalid_q, rvalid_d;
    logic [1:0]    rresp_q, rresp_d;
    logic [31:0]   rdata_q, rdata_d;

    assign s_axi_awready = ce && !aw_full_q && !bvalid_q;
    assign s_axi_wready  = ce && !w_full_q && !bvalid_q;
    assign s_axi_arready = ce && !rvalid_q;
    assign wr_en    = ce && aw_full_q && w_full_q && !bvalid_q;
    assign wr_index = 8'(awaddr_q[AW-1:2]);
    assign wr_data  = wdata_q;
    assign wr_strb  = wstrb_q;
    assign rd_en    = s_axi_arvalid && s_axi_arready;
    assign rd_index = 8'(s_axi_araddr[AW-1:2]);

    // capture address and data in either order, answer once both held
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (wr_en) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (rd_en) begin
            rvalid_d = 1'b1;
            rdata_d  = rd_data;
            rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
        end else if (ce) begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;
endmodule : axil_reg_slave
`default_nettype wire

//--- hw/window_alarm.sv
// one window comparator with release margin and a held alarm flag
`timescale 1ns/1ps
`default_nettype none
module window_alarm
    import alarm_window_pkg::*;
#(
    parameter int W = 12
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample,
    input  wire logic [W-1:0] upper_bound_field,
    input  wire logic [W-1:0] lower_bound_field,
    input  wire logic [W-1:0] margin,
    input  wire logic         signed_mode,
    output logic              input_alarm_flag
);
    logic         alarm_q;
    logic         alarm_d;
    logic [W+1:0] s_x;
    logic [W+1:0] hi_x;
    logic [W+1:0] lo_x;
    logic [W+1:0] m_x;

    // widen to a common signed range so margins never wrap
    always_comb begin
        s_x  = signed_mode ? {{2{sample[W-1]}}, sample} : {2'b00, sample};
        hi_x = signed_mode ? {{2{upper_bound_field[W-1]}}, upper_bound_field}
                           : {2'b00, upper_bound_field};
        lo_x = signed_mode ? {{2{lower_bound_field[W-1]}}, lower_bound_field}
                           : {2'b00, lower_bound_field};
        m_x  = {2'b00, margin};
    end

    // raise outside the window, release only inside by the margin
    always_comb begin
        alarm_d = alarm_q;
        if (sample_valid) begin
            if (($signed(s_x) > $signed(hi_x)) || ($signed(s_x) < $signed(lo_x))) begin
                alarm_d = 1'b1;
            end else if (alarm_q && ($signed(s_x) <= $signed(hi_x - m_x))
                         && ($signed(s_x) >= $signed(lo_x + m_x))) begin
                alarm_d = 1'b0;
            end
        end
    end

    // alarm register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_q <= 1'b0;
        end else if (ce) begin
            alarm_q <= alarm_d;
        end
    end

    assign input_alarm_flag = alarm_q;
endmodule : window_alarm
`default_nettype wire
